// file: csi_core.sv
/*
 * csi_core: call stack registers and indirect addressing path, with a
 * classic wishbone slave for the software-visible registers.
 * registers, one per word, data in the low byte:
 *   0x00 config: bit 0 enables the stack fault reset, set after reset
 *   0x04 power control status: bit 7 overflow, bit 6 underflow;
 *        a written 0 clears a flag, a written 1 keeps it
 *   0x08 stack position, five bits, all ones when the stack is empty
 *   0x0c top entry low byte, 0x10 top entry high seven bits
 *   0x14 / 0x18 pointer 0 low / high byte
 *   0x1c / 0x20 pointer 1 low / high byte
 *   other offsets read 0 and ignore writes
 * indirect map seen through a pointer:
 *   0x0000-0x0fff banked data memory, port offsets 0x00/0x01 read 0
 *   0x2000-0x29af linear view of the general RAM of successive banks
 *   bit 15 set: low byte of a flash word, read only
 *   everything else reads 0 and ignores writes
 * interfaces:
 *   stack port: push or pop pulses with the pc to push; push wins
 *   indirect port: one request at a time, done pulses when finished
 *   data memory request: registered, one cycle per access
 *   flash request: registered, one cycle per read
 * timing: the bus acks with one wait state; an indirect access ends
 * two cycles after its request for data memory, three for flash.
 * reset: stack position all ones, fault reset enabled, flags and
 * pointers cleared.
 * limits: a push or pop in the same cycle as a write of the stack
 * position or top entry wins and the write is lost; a stack event
 * beats a flag clear; an indirect request while one is open is dropped;
 * the fault reset output is a one-cycle request, the reset itself is
 * done outside this block.
 * assumes: core logic on SYS_CLK drives stack and indirect requests;
 * data memory and program flash answer combinationally while requested.
 */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - pointer selects entry, top pair reads/writes it
// - stack pointer is five bits wide
// - calls and interrupts increment, returns decrement
// - push increments then stores; pop loads then decrements
// - fault reset enabled: reset and set flag
// - access port redirects to pointer address
// - pointer at port: read zero, no write
// - pointer is high byte concatenated with low
// - addresses 0x000-0xFFF select banked memory directly
// - 0x2000-0x29AF is linear window over general RAM
// - unimplemented linear memory reads as zero
// - common memory excluded from linear window
// - pointer bit 15 selects program flash
// - flash reads return low eight bits
// - flash writes through port have no effect
// - flash access takes one extra cycle
// - sixteen entries of fifteen bits, separate space
// - fault reset off: wraps; flags always set
// - reset loads pointer with all ones
module csi_core (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire csi_pkg::csi_stk_req_s STK_REQ,
	output logic [14:0] POP_PC,
	output logic STACK_FAULT_RST,
	input wire csi_pkg::csi_ind_req_s IND_REQ,
	output logic IND_DONE,
	output logic [7:0] IND_RDATA,
	output csi_pkg::csi_mem_req_s MEM_REQ,
	input wire logic [7:0] MEM_RDATA,
	output logic FLASH_REQ,
	output logic [14:0] FLASH_ADDR,
	input wire logic [13:0] FLASH_RDATA
);

	// ============================================================
	// address map
	function automatic csi_pkg::csi_map_s csi_map(input logic [15:0] a);
		csi_pkg::csi_map_s m;
		logic [11:0] n;
		logic [4:0] q;
		m.tgt = csi_pkg::CSI_TGT_NULL;
		m.addr = 12'h000;
		n = 12'h000;
		q = 5'h00;
		if (a[15]) begin
			m.tgt = csi_pkg::CSI_TGT_FLASH;
		end else if (a <= csi_pkg::CSI_TRAD_LAST) begin
			m.addr = a[11:0];
			if (a[6:0] == csi_pkg::CSI_PORT0_OFS || a[6:0] == csi_pkg::CSI_PORT1_OFS) begin
				m.tgt = csi_pkg::CSI_TGT_NULL;
			end else begin
				m.tgt = csi_pkg::CSI_TGT_MEM;
			end
		end else if (a >= csi_pkg::CSI_LIN_BASE && a <= csi_pkg::CSI_LIN_LAST) begin
			n = a[11:0];
			for (int i = 0; i < csi_pkg::CSI_DIV_STEPS; i++) begin
				if (n >= csi_pkg::CSI_GPR_SIZE) begin
					n = n - csi_pkg::CSI_GPR_SIZE;
					q = q + 5'h01;
				end
			end
			m.addr = {q, csi_pkg::CSI_GPR_BASE + n[6:0]};
			if (q < csi_pkg::CSI_LIN_BANKS) begin
				m.tgt = csi_pkg::CSI_TGT_MEM;
			end else begin
				m.tgt = csi_pkg::CSI_TGT_NULL;
			end
		end
		return m;
	endfunction

	// ============================================================
	// register helpers
	// register offset match, shared by the stack position and top entry write decodes
	function automatic logic csi_hit(input logic [7:0] adr, input logic [7:0] ofs);
		return adr == ofs;
	endfunction

	// ============================================================
	// declarations
	csi_pkg::csi_core_s cur_ff;
	csi_pkg::csi_core_s nxt_cur;
	csi_pkg::csi_map_s map;
	logic [15:0] sel_ptr;
	logic bus_req;
	logic bus_take;
	logic bus_wr;
	logic wr_pos;
	logic wr_lo;
	logic wr_hi;
	logic [4:0] stk_ptr;
	logic [14:0] stk_tos;
	logic stk_ovf;
	logic stk_unf;
	logic [31:0] rd_mux;

	// ============================================================
	// bus decode
	assign bus_req = WB_CYC_I & WB_STB_I;
	assign bus_take = bus_req & ~cur_ff.ack;
	assign bus_wr = bus_req & WB_WE_I & WB_SEL_I[0] & cur_ff.ack;
	assign wr_pos = bus_wr & csi_hit(WB_ADR_I, csi_pkg::CSI_OFS_STKPOS);
	assign wr_lo = bus_wr & csi_hit(WB_ADR_I, csi_pkg::CSI_OFS_TOP_LO);
	assign wr_hi = bus_wr & csi_hit(WB_ADR_I, csi_pkg::CSI_OFS_TOP_HI);
	assign sel_ptr = IND_REQ.sel ? cur_ff.ptr1 : cur_ff.ptr0;
	assign map = csi_map(sel_ptr);

	// ============================================================
	// return stack
	csi_stack u_stack (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.req(STK_REQ),
		.fault_en(cur_ff.fault_en),
		.sw_ptr_we(wr_pos),
		.sw_lo_we(wr_lo),
		.sw_hi_we(wr_hi),
		.sw_data(WB_DAT_I[7:0]),
		.ptr(stk_ptr),
		.tos(stk_tos),
		.pop_pc(POP_PC),
		.ovf(stk_ovf),
		.unf(stk_unf),
		.fault_rst(STACK_FAULT_RST)
	);

	// ============================================================
	// read mux
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (WB_ADR_I)
			csi_pkg::CSI_OFS_CONFIG: begin
				rd_mux[csi_pkg::CSI_CFG_FAULT_BIT] = cur_ff.fault_en;
			end
			csi_pkg::CSI_OFS_PCS: begin
				rd_mux[csi_pkg::CSI_PCS_OVF_BIT] = cur_ff.ovf;
				rd_mux[csi_pkg::CSI_PCS_UNF_BIT] = cur_ff.unf;
			end
			csi_pkg::CSI_OFS_STKPOS: begin
				rd_mux[4:0] = stk_ptr;
			end
			csi_pkg::CSI_OFS_TOP_LO: begin
				rd_mux[7:0] = stk_tos[7:0];
			end
			csi_pkg::CSI_OFS_TOP_HI: begin
				rd_mux[6:0] = stk_tos[14:8];
			end
			csi_pkg::CSI_OFS_PTR0_LO: begin
				rd_mux[7:0] = cur_ff.ptr0[7:0];
			end
			csi_pkg::CSI_OFS_PTR0_HI: begin
				rd_mux[7:0] = cur_ff.ptr0[15:8];
			end
			csi_pkg::CSI_OFS_PTR1_LO: begin
				rd_mux[7:0] = cur_ff.ptr1[7:0];
			end
			csi_pkg::CSI_OFS_PTR1_HI: begin
				rd_mux[7:0] = cur_ff.ptr1[15:8];
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// ============================================================
	// next state
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.done = 1'b0;

		// bus slave: one wait state, ack for one cycle
		nxt_cur.ack = bus_take;
		if (bus_take) begin
			nxt_cur.dat = rd_mux;
		end

		// software registers
		if (bus_wr) begin
			unique case (WB_ADR_I)
				csi_pkg::CSI_OFS_CONFIG: begin
					nxt_cur.fault_en = WB_DAT_I[csi_pkg::CSI_CFG_FAULT_BIT];
				end
				csi_pkg::CSI_OFS_PCS: begin
					nxt_cur.ovf = cur_ff.ovf & WB_DAT_I[csi_pkg::CSI_PCS_OVF_BIT];
					nxt_cur.unf = cur_ff.unf & WB_DAT_I[csi_pkg::CSI_PCS_UNF_BIT];
				end
				csi_pkg::CSI_OFS_PTR0_LO: begin
					nxt_cur.ptr0[7:0] = WB_DAT_I[7:0];
				end
				csi_pkg::CSI_OFS_PTR0_HI: begin
					nxt_cur.ptr0[15:8] = WB_DAT_I[7:0];
				end
				csi_pkg::CSI_OFS_PTR1_LO: begin
					nxt_cur.ptr1[7:0] = WB_DAT_I[7:0];
				end
				csi_pkg::CSI_OFS_PTR1_HI: begin
					nxt_cur.ptr1[15:8] = WB_DAT_I[7:0];
				end
				default: begin
					nxt_cur.fault_en = cur_ff.fault_en;
				end
			endcase
		end

		// flags: a stack event beats a clear in the same cycle
		if (stk_ovf) begin
			nxt_cur.ovf = 1'b1;
		end
		if (stk_unf) begin
			nxt_cur.unf = 1'b1;
		end

		// indirect access sequencer
		unique case (cur_ff.st)
			csi_pkg::CSI_ST_IDLE: begin
				if (IND_REQ.valid) begin
					nxt_cur.we = IND_REQ.we;
					unique case (map.tgt)
						csi_pkg::CSI_TGT_MEM: begin
							nxt_cur.mem.req = 1'b1;
							nxt_cur.mem.we = IND_REQ.we;
							nxt_cur.mem.addr = map.addr;
							nxt_cur.mem.wdata = IND_REQ.wdata;
							nxt_cur.st = csi_pkg::CSI_ST_MEM;
						end
						csi_pkg::CSI_TGT_FLASH: begin
							nxt_cur.flash_req = ~IND_REQ.we;
							nxt_cur.flash_addr = sel_ptr[14:0];
							nxt_cur.st = csi_pkg::CSI_ST_FWAIT;
						end
						default: begin
							nxt_cur.mem.req = 1'b0;
							nxt_cur.st = csi_pkg::CSI_ST_MEM;
						end
					endcase
				end
			end
			csi_pkg::CSI_ST_MEM: begin
				if (cur_ff.mem.req & ~cur_ff.we) begin
					nxt_cur.rdata = MEM_RDATA;
				end else begin
					nxt_cur.rdata = 8'h00;
				end
				nxt_cur.mem.req = 1'b0;
				nxt_cur.done = 1'b1;
				nxt_cur.st = csi_pkg::CSI_ST_IDLE;
			end
			csi_pkg::CSI_ST_FWAIT: begin
				if (cur_ff.flash_req) begin
					nxt_cur.rdata = FLASH_RDATA[7:0];
				end else begin
					nxt_cur.rdata = 8'h00;
				end
				nxt_cur.flash_req = 1'b0;
				nxt_cur.st = csi_pkg::CSI_ST_FCAP;
			end
			csi_pkg::CSI_ST_FCAP: begin
				nxt_cur.done = 1'b1;
				nxt_cur.st = csi_pkg::CSI_ST_IDLE;
			end
		endcase
	end

	// ============================================================
	// state register
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			cur_ff <= '0;
			cur_ff.fault_en <= csi_pkg::CSI_CFG_RST;
			cur_ff.st <= csi_pkg::CSI_ST_IDLE;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ============================================================
	// outputs
	assign WB_DAT_O = cur_ff.dat;
	assign WB_ACK_O = cur_ff.ack;
	assign IND_DONE = cur_ff.done;
	assign IND_RDATA = cur_ff.rdata;
	assign MEM_REQ = cur_ff.mem;
	assign FLASH_REQ = cur_ff.flash_req;
	assign FLASH_ADDR = cur_ff.flash_addr;

endmodule

`default_nettype wire

// file: csi_core_sva.sv
/* csi_core_sva: port checker for csi_core.
 * assumes: bound to csi_core, one clock, reset active low. */
`timescale 1ns/1ns
`default_nettype none
module csi_core_sva (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	input wire csi_pkg::csi_stk_req_s STK_REQ,
	input wire logic [14:0] POP_PC,
	input wire logic STACK_FAULT_RST,
	input wire logic IND_DONE,
	input wire logic [7:0] IND_RDATA,
	input wire csi_pkg::csi_mem_req_s MEM_REQ,
	input wire logic [7:0] MEM_RDATA,
	input wire logic FLASH_REQ
);
	// ====================
	// checks
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	a_ack_wait: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack late");
	a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack too long");
	a_mem_done: assert property (MEM_REQ.req |=> IND_DONE)
		else $error("memory done late");
	a_mem_rdata: assert property (MEM_REQ.req && !MEM_REQ.we |=> IND_RDATA == $past(MEM_RDATA))
		else $error("memory data lost");
	a_port_skip: assert property (MEM_REQ.req |-> MEM_REQ.addr[6:1] != 6'h00)
		else $error("port register reached");
	a_flash_wait: assert property (FLASH_REQ |=> !IND_DONE ##1 IND_DONE)
		else $error("flash timing");
	a_flash_nomem: assert property (FLASH_REQ |-> !MEM_REQ.req [*3])
		else $error("memory touched by flash");
	a_fault_pulse: assert property (STACK_FAULT_RST |=> !STACK_FAULT_RST)
		else $error("fault too long");
	a_pop_only: assert property (!$stable(POP_PC) |-> $past(STK_REQ.pop))
		else $error("pop value without pop");
	a_done_pulse: assert property (IND_DONE |=> !IND_DONE)
		else $error("done too long");
endmodule
`default_nettype wire

// file: csi_core_tb_top.sv
/* csi_core_tb_top: self-checking bench for csi_core.
 * assumes: csi_mem_model answers memory and flash. */
`timescale 1ns/1ns
`default_nettype none
module csi_core_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic [14:0] pop_pc;
	logic fault;
	logic done;
	logic [7:0] ind_rd;
	logic [7:0] mrd;
	logic freq;
	logic [14:0] faddr;
	logic [13:0] frd;
	csi_pkg::csi_stk_req_s stk = '0;
	csi_pkg::csi_ind_req_s ind = '0;
	csi_pkg::csi_mem_req_s mreq;
	int n_tests = 0;
	int n_mismatch = 0;
	int n_fault = 0;
	csi_core i_dut (.SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .STK_REQ(stk), .POP_PC(pop_pc), .STACK_FAULT_RST(fault),
		.IND_REQ(ind), .IND_DONE(done), .IND_RDATA(ind_rd), .MEM_REQ(mreq),
		.MEM_RDATA(mrd), .FLASH_REQ(freq), .FLASH_ADDR(faddr), .FLASH_RDATA(frd));
	csi_mem_model i_mem (.clk(clk), .mreq(mreq), .mrd(mrd), .freq(freq), .faddr(faddr),
		.frd(frd));
	// ====================
	// helpers
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (fault === 1'b1) n_fault++;
	end
	function automatic logic [14:0] pcv(input int k);
		return 15'h1234 + 15'(k) * 15'h0411;
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk(nm, e, r);
	endtask
	task automatic push_n(input int n, input int b);
		for (int k = 0; k < n; k++) begin
			stk <= {2'b10, pcv(b + k)};
			@(posedge clk);
		end
		stk <= '0;
		@(posedge clk);
	endtask
	task automatic pop1;
		stk <= {2'b01, 15'h0000};
		@(posedge clk);
		stk <= '0;
		@(posedge clk);
	endtask
	task automatic setp(input logic s, input logic [15:0] p);
		wr(s ? csi_pkg::CSI_OFS_PTR1_LO : csi_pkg::CSI_OFS_PTR0_LO, 32'(p[7:0]));
		wr(s ? csi_pkg::CSI_OFS_PTR1_HI : csi_pkg::CSI_OFS_PTR0_HI, 32'(p[15:8]));
	endtask
	task automatic iop(input logic s, input logic w, input logic [7:0] d,
		output logic [7:0] r, output int c);
		c = 0;
		ind <= {1'b1, s, w, d};
		@(posedge clk);
		ind <= '0;
		while (done !== 1'b1) begin
			c++;
			@(posedge clk);
		end
		r = ind_rd;
	endtask
	// ====================
	// scenarios
	task automatic t_stack;
		logic [14:0] p;
		push_n(16, 0);
		rc("stkpos", csi_pkg::CSI_OFS_STKPOS, 32'h0f);
		wr(csi_pkg::CSI_OFS_STKPOS, 32'h3);
		p = pcv(3);
		rc("top_lo", csi_pkg::CSI_OFS_TOP_LO, 32'(p[7:0]));
		rc("top_hi", csi_pkg::CSI_OFS_TOP_HI, 32'(p[14:8]));
		wr(csi_pkg::CSI_OFS_TOP_LO, 32'h5a);
		wr(csi_pkg::CSI_OFS_TOP_HI, 32'h25);
		rc("top_lo_wr", csi_pkg::CSI_OFS_TOP_LO, 32'h5a);
		rc("top_hi_wr", csi_pkg::CSI_OFS_TOP_HI, 32'h25);
		wr(csi_pkg::CSI_OFS_STKPOS, 32'h0f);
		for (int k = 15; k >= 0; k--) begin
			pop1();
			chk("pop_pc", (k == 3) ? 32'h255a : 32'(pcv(k)), 32'(pop_pc));
		end
		rc("stkpos", csi_pkg::CSI_OFS_STKPOS, 32'h1f);
		$display("t_stack done");
	endtask
	task automatic t_fault;
		push_n(17, 0);
		rc("pcs", csi_pkg::CSI_OFS_PCS, 32'h80);
		chk("faults", 32'h1, 32'(n_fault));
		rc("stkpos", csi_pkg::CSI_OFS_STKPOS, 32'h1f);
		wr(csi_pkg::CSI_OFS_PCS, 32'h0);
		pop1();
		rc("pcs", csi_pkg::CSI_OFS_PCS, 32'h40);
		wr(csi_pkg::CSI_OFS_PCS, 32'h0);
		wr(csi_pkg::CSI_OFS_CONFIG, 32'h0);
		push_n(17, 0);
		rc("pcs", csi_pkg::CSI_OFS_PCS, 32'h80);
		pop1();
		chk("wrap", 32'(pcv(16)), 32'(pop_pc));
		chk("faults", 32'h2, 32'(n_fault));
		$display("t_fault done");
	endtask
	task automatic t_ind;
		logic [7:0] r;
		logic [11:0] a;
		int c;
		int n;
		logic [15:0] lin [4] = '{16'h2000, 16'h204f, 16'h2050, 16'h29af};
		setp(1'b0, 16'h0123);
		iop(1'b0, 1'b1, 8'h5c, r, c);
		chk("mem", 32'h5c, 32'(i_mem.mem[12'h123]));
		iop(1'b0, 1'b0, 8'h00, r, c);
		chk("rd", 32'h5c, 32'(r));
		chk("lat", 32'h2, 32'(c));
		n = i_mem.n_wr;
		setp(1'b1, 16'h0081);
		iop(1'b1, 1'b1, 8'hff, r, c);
		iop(1'b1, 1'b0, 8'h00, r, c);
		chk("port", 32'h0, 32'(r));
		chk("port_wr", 32'(n), 32'(i_mem.n_wr));
		for (int k = 0; k < 4; k++) begin
			n = int'(lin[k]) - 32'h2000;
			a = 12'((n / 80) * 128 + 32 + n % 80);
			setp(1'b0, lin[k]);
			iop(1'b0, 1'b1, 8'h80 | 8'(k), r, c);
			chk("lin_wr", 32'h80 | 32'(k), 32'(i_mem.mem[a]));
			iop(1'b0, 1'b0, 8'h00, r, c);
			chk("lin_rd", 32'h80 | 32'(k), 32'(r));
		end
		chk("common", 32'(8'h70 ^ 8'h3c), 32'(i_mem.mem[12'h070]));
		n = i_mem.n_wr;
		setp(1'b0, 16'h29b0);
		iop(1'b0, 1'b1, 8'h11, r, c);
		iop(1'b0, 1'b0, 8'h00, r, c);
		chk("unimpl", 32'h0, 32'(r));
		setp(1'b1, 16'h8155);
		iop(1'b1, 1'b0, 8'h00, r, c);
		chk("flash", 32'h0f, 32'(r));
		chk("flash_lat", 32'h3, 32'(c));
		iop(1'b1, 1'b1, 8'h77, r, c);
		chk("flash_wr", 32'(n), 32'(i_mem.n_wr));
		iop(1'b1, 1'b0, 8'h00, r, c);
		chk("flash_keep", 32'h0f, 32'(r));
		$display("t_ind done");
	endtask
	task automatic t_reset;
		rc("config", csi_pkg::CSI_OFS_CONFIG, 32'h1);
		rc("stkpos", csi_pkg::CSI_OFS_STKPOS, 32'h1f);
		rc("unmapped", 8'h24, 32'h0);
		$display("t_reset done");
	endtask
	task automatic test_done;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		test_done();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_stack();
		t_fault();
		t_ind();
		test_done();
	end
endmodule
bind csi_core csi_core_sva i_sva (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .STK_REQ(STK_REQ), .POP_PC(POP_PC),
	.STACK_FAULT_RST(STACK_FAULT_RST), .IND_DONE(IND_DONE), .IND_RDATA(IND_RDATA),
	.MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA), .FLASH_REQ(FLASH_REQ));
`default_nettype wire

// file: csi_mem_model.sv
/* csi_mem_model: data memory and program flash beside the indirect path.
 * assumes: answers combinationally while requested. */
`timescale 1ns/1ns
`default_nettype none
module csi_mem_model (
	input wire logic clk,
	input wire csi_pkg::csi_mem_req_s mreq,
	output logic [7:0] mrd,
	input wire logic freq,
	input wire logic [14:0] faddr,
	output logic [13:0] frd
);
	logic [7:0] mem [4096];
	logic [7:0] last_m = 8'h00;
	logic [13:0] last_f = 14'h0000;
	int n_wr = 0;
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 8'(i) ^ 8'h3c;
		end
	end
	// released lines show the inverse of the last value
	assign mrd = mreq.req ? mem[mreq.addr] : ~last_m;
	assign frd = freq ? (faddr[13:0] ^ 14'h2a5a) : ~last_f;
	always @(posedge clk) begin
		if (mreq.req) last_m <= mrd;
		if (freq) last_f <= frd;
		if (mreq.req && mreq.we) begin
			mem[mreq.addr] <= mreq.wdata;
			n_wr <= n_wr + 1;
		end
	end
endmodule
`default_nettype wire

// file: csi_pkg.sv
/*
 * csi_pkg: constants, register offsets and carrier types for the call stack
 * and indirect addressing block.
 * assumes: one 100 MHz system clock, synchronous active-low reset.
 */
`default_nettype none

package csi_pkg;

	// ============================================================
	// register offsets, wishbone byte addresses
	localparam logic [7:0] CSI_OFS_CONFIG = 8'h00;
	localparam logic [7:0] CSI_OFS_PCS = 8'h04;
	localparam logic [7:0] CSI_OFS_STKPOS = 8'h08;
	localparam logic [7:0] CSI_OFS_TOP_LO = 8'h0c;
	localparam logic [7:0] CSI_OFS_TOP_HI = 8'h10;
	localparam logic [7:0] CSI_OFS_PTR0_LO = 8'h14;
	localparam logic [7:0] CSI_OFS_PTR0_HI = 8'h18;
	localparam logic [7:0] CSI_OFS_PTR1_LO = 8'h1c;
	localparam logic [7:0] CSI_OFS_PTR1_HI = 8'h20;

	// ============================================================
	// field positions and reset values
	localparam int CSI_CFG_FAULT_BIT = 0;
	localparam int CSI_PCS_OVF_BIT = 7;
	localparam int CSI_PCS_UNF_BIT = 6;
	localparam logic CSI_CFG_RST = 1'h1;
	localparam logic [4:0] CSI_PTR_RST = 5'h1f;
	localparam logic [4:0] CSI_PTR_TOP = 5'h0f;

	// ============================================================
	// indirect address map
	localparam logic [15:0] CSI_TRAD_LAST = 16'h0fff;
	localparam logic [15:0] CSI_LIN_BASE = 16'h2000;
	localparam logic [15:0] CSI_LIN_LAST = 16'h29af;
	localparam logic [11:0] CSI_GPR_SIZE = 12'h050;
	localparam logic [6:0] CSI_GPR_BASE = 7'h20;
	localparam logic [6:0] CSI_PORT0_OFS = 7'h00;
	localparam logic [6:0] CSI_PORT1_OFS = 7'h01;
	localparam logic [4:0] CSI_LIN_BANKS = 5'h1f;
	localparam int CSI_DIV_STEPS = 31;

	// ============================================================
	// types
	typedef enum logic [1:0] {
		CSI_TGT_MEM = 2'b00,
		CSI_TGT_NULL = 2'b01,
		CSI_TGT_FLASH = 2'b10
	} csi_tgt_e;

	typedef enum logic [1:0] {
		CSI_ST_IDLE = 2'b00,
		CSI_ST_MEM = 2'b01,
		CSI_ST_FWAIT = 2'b10,
		CSI_ST_FCAP = 2'b11
	} csi_ind_state_e;

	typedef struct packed {
		logic push;
		logic pop;
		logic [14:0] pc;
	} csi_stk_req_s;

	typedef struct packed {
		logic valid;
		logic sel;
		logic we;
		logic [7:0] wdata;
	} csi_ind_req_s;

	typedef struct packed {
		logic req;
		logic we;
		logic [11:0] addr;
		logic [7:0] wdata;
	} csi_mem_req_s;

	typedef struct packed {
		csi_tgt_e tgt;
		logic [11:0] addr;
	} csi_map_s;

	typedef struct packed {
		logic [4:0] ptr;
		logic [15:0][14:0] mem;
		logic [14:0] pop_pc;
		logic ovf;
		logic unf;
		logic fault;
	} csi_stk_s;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic fault_en;
		logic ovf;
		logic unf;
		logic [15:0] ptr0;
		logic [15:0] ptr1;
		csi_ind_state_e st;
		logic we;
		logic done;
		logic [7:0] rdata;
		csi_mem_req_s mem;
		logic flash_req;
		logic [14:0] flash_addr;
	} csi_core_s;

endpackage

`default_nettype wire

// file: csi_stack.sv
/*
 * csi_stack: sixteen-entry return address stack with a 5-bit pointer,
 * overflow and underflow detection and software access to any entry.
 * assumes: push and pop come from core logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module csi_stack (
	input wire logic clk,
	input wire logic rst_n,
	input wire csi_pkg::csi_stk_req_s req,
	input wire logic fault_en,
	input wire logic sw_ptr_we,
	input wire logic sw_lo_we,
	input wire logic sw_hi_we,
	input wire logic [7:0] sw_data,
	output logic [4:0] ptr,
	output logic [14:0] tos,
	output logic [14:0] pop_pc,
	output logic ovf,
	output logic unf,
	output logic fault_rst
);

	// ============================================================
	// helpers
	function automatic logic [3:0] csi_idx(input logic [4:0] p);
		return p[3:0];
	endfunction

	csi_pkg::csi_stk_s cur_ff;
	csi_pkg::csi_stk_s nxt_cur;
	logic [4:0] up_ptr;

	// ============================================================
	// next state
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.ovf = 1'b0;
		nxt_cur.unf = 1'b0;
		nxt_cur.fault = 1'b0;
		up_ptr = cur_ff.ptr + 5'h01;
		if (req.push) begin
			nxt_cur.ptr = up_ptr;
			nxt_cur.mem[csi_idx(up_ptr)] = req.pc;
			if (cur_ff.ptr == csi_pkg::CSI_PTR_TOP) begin
				nxt_cur.ovf = 1'b1;
				if (fault_en) begin
					nxt_cur.fault = 1'b1;
					nxt_cur.ptr = csi_pkg::CSI_PTR_RST;
				end
			end
		end else if (req.pop) begin
			nxt_cur.pop_pc = cur_ff.mem[csi_idx(cur_ff.ptr)];
			nxt_cur.ptr = cur_ff.ptr - 5'h01;
			if (cur_ff.ptr == csi_pkg::CSI_PTR_RST) begin
				nxt_cur.unf = 1'b1;
				if (fault_en) begin
					nxt_cur.fault = 1'b1;
					nxt_cur.ptr = csi_pkg::CSI_PTR_RST;
				end
			end
		end else begin
			if (sw_ptr_we) begin
				nxt_cur.ptr = sw_data[4:0];
			end
			if (sw_lo_we) begin
				nxt_cur.mem[csi_idx(cur_ff.ptr)][7:0] = sw_data;
			end
			if (sw_hi_we) begin
				nxt_cur.mem[csi_idx(cur_ff.ptr)][14:8] = sw_data[6:0];
			end
		end
	end

	// ============================================================
	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cur_ff <= '0;
			cur_ff.ptr <= csi_pkg::CSI_PTR_RST;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign ptr = cur_ff.ptr;
	assign tos = cur_ff.mem[csi_idx(cur_ff.ptr)];
	assign pop_pc = cur_ff.pop_pc;
	assign ovf = cur_ff.ovf;
	assign unf = cur_ff.unf;
	assign fault_rst = cur_ff.fault;

endmodule

`default_nettype wire
